// file: dma_local_memory_channel_engine_tb_top.sv
// self-checking bench of the dma channel engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, e, a); end end
module dma_local_memory_channel_engine_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cpu_req = 1'b0;
  logic tx_en = 1'b0;
  logic [21:0] mem_rdata = 22'h0;
  logic ws_req = 1'b0;
  logic [1:0] disc = 2'h0;
  logic [23:0] nib_exp;
  logic [31:0] prdata, go_fn_strobe, rd;
  logic pready, pslverr, cpu_ack, mem_we, mem_re, go_fn, fn_nibble_valid, carry, sync_pulse, perr;
  logic [1:0] rdy_in, ack_in, ch_rdy_out, ch_ack_out, ch_disc_out;
  logic [15:0] din0, din1, ch_data_out0, ch_data_out1, mem_addr;
  logic [21:0] mem_wdata;
  logic [4:0] go_fn_chan;
  logic [3:0] fn_nibble;
  logic [21:0] mem [16];
  logic [15:0] wk = 16'h0;
  logic [15:0] rk = 16'h0;
  logic [15:0] dk = 16'h0;
  int error_cnt = 0;
  int comparisons = 0;
  logic [28:0] rows [3] = '{{4'h4, 4'h3, 5'h08, 16'h1234}, {4'h7, 4'hf, 5'h1f, 16'hfedc},
    {4'h8, 4'h0, 5'h03, 16'h0000}};
  always #10 ref_clk = ~ref_clk;
  dmc_engine dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_memory_or_fetch_request(cpu_req), .cpu_ack(cpu_ack), .ws_req(ws_req),
    .ch_rdy_in(rdy_in), .ch_ack_in(ack_in), .ch_disc_in(disc), .ch_data_in0(din0),
    .ch_data_in1(din1), .ch_rdy_out(ch_rdy_out), .ch_ack_out(ch_ack_out),
    .ch_disc_out(ch_disc_out), .ch_data_out0(ch_data_out0), .ch_data_out1(ch_data_out1),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata), .go_fn(go_fn), .go_fn_chan(go_fn_chan), .go_fn_strobe(go_fn_strobe),
    .fn_nibble(fn_nibble), .fn_nibble_valid(fn_nibble_valid), .carry(carry),
    .sync_pulse(sync_pulse));
  dmc_chan_model chan0 (.ref_clk(ref_clk), .reset_n(reset_n), .sync_pulse(sync_pulse),
    .tx_en(tx_en), .ack_out(ch_ack_out[0]), .rdy_out(ch_rdy_out[0]), .rdy_in(rdy_in[0]),
    .ack_in(ack_in[0]), .data_in(din0));
  dmc_chan_model chan1 (.ref_clk(ref_clk), .reset_n(reset_n), .sync_pulse(sync_pulse),
    .tx_en(1'b0), .ack_out(ch_ack_out[1]), .rdy_out(ch_rdy_out[1]), .rdy_in(rdy_in[1]),
    .ack_in(ack_in[1]), .data_in(din1));
  task finish_test();
    $display("counts: error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge ref_clk);
    if (n == 50) begin
      error_cnt++;
      finish_test();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task setfn(input logic [3:0] c, input logic [3:0] m, input logic [4:0] ch, input logic [15:0] a);
    apb(1'b1, 8'h04, {16'h0000, a});
    apb(1'b1, 8'h00, {19'h0, c, m, ch});
    #1;
  endtask : setfn
  task wait_stat(input int b);
    int n;
    for (n = 0; n < 400; n++) begin
      apb(1'b0, 8'h08, 32'h0);
      if (rd[b] === 1'b1) break;
    end
    if (n == 400) begin
      error_cnt++;
      finish_test();
    end
  endtask : wait_stat
  // memory answers one cycle after mem_re and shows a toggling word otherwise
  always @(posedge ref_clk) begin
    mem_rdata <= (mem_re === 1'b1) ? mem[mem_addr[3:0]] : ~mem_rdata;
    if (mem_we === 1'b1) begin
      `CHK("mem_addr", 16'h0010 + wk, mem_addr)
      `CHK("mem_data", 16'ha000 + wk, mem_wdata[15:0])
      // second word stored with one flipped data bit so the read must correct it
      mem[mem_addr[3:0]] <= mem_wdata ^ {21'h0, wk[0]};
      wk <= wk + 16'h1;
    end
    if (ch_rdy_out[1] === 1'b1) begin
      `CHK("rd_data", 16'ha000 + rk, ch_data_out1)
      rk <= rk + 16'h1;
    end
    if (ch_disc_out[1] === 1'b1) dk <= dk + 16'h1;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    `CHK("status", 32'h0, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("pslverr", 1'b1, perr)
    $display("reset and map test done");
    for (int i = 0; i < 3; i++) begin
      setfn(rows[i][28:25], rows[i][24:21], rows[i][20:16], rows[i][15:0]);
      `CHK("go_fn", 1'b1, go_fn)
      `CHK("go_chan", rows[i][20:16], go_fn_chan)
      `CHK("strobe", 32'h1 << rows[i][20:16], go_fn_strobe)
      nib_exp = {rows[i][15:0], rows[i][28:25], rows[i][24:21]};
      for (int j = 0; j < 6; j++) begin
        @(posedge ref_clk);
        #1;
        `CHK("nibble", nib_exp[j * 4 +: 4], fn_nibble)
        `CHK("nib_valid", 1'b1, fn_nibble_valid)
      end
    end
    $display("function fanout test done");
    @(posedge ref_clk);
    cpu_req <= 1'b1;
    setfn(4'h8, 4'h0, 5'h08, 16'h0010);
    `CHK("go_fn", 1'b0, go_fn)
    setfn(4'h9, 4'h0, 5'h08, 16'h0002);
    setfn(4'hc, 4'h0, 5'h08, 16'h0000);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("acc", 32'h10, rd)
    setfn(4'h1, 4'h0, 5'h08, 16'h0000);
    tx_en <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    `CHK("busy", 1'b1, rd[0])
    wait_stat(2);
    `CHK("writes", 16'h2, wk)
    `CHK("busy", 1'b0, rd[0])
    `CHK("held", 1'b1, rd[7])
    setfn(4'h3, 4'h0, 5'h08, 16'h0000);
    @(posedge ref_clk);
    #1;
    `CHK("carry", 1'b1, carry)
    setfn(4'h1, 4'h0, 5'h08, 16'h0000);
    @(posedge ref_clk);
    // held three cycles so it covers one of the disconnect phases
    disc <= 2'h1;
    repeat (3) @(posedge ref_clk);
    disc <= 2'h0;
    wait_stat(2);
    `CHK("held_kept", 16'h2, wk)
    $display("write test done");
    @(posedge ref_clk);
    cpu_req <= 1'b0;
    setfn(4'h8, 4'h0, 5'h09, 16'h0010);
    setfn(4'h9, 4'h0, 5'h09, 16'h0002);
    @(posedge ref_clk);
    ws_req <= 1'b1;
    setfn(4'h1, 4'h1, 5'h09, 16'h0000);
    repeat (20) @(posedge ref_clk);
    `CHK("ws_block", 16'h0, rk)
    ws_req <= 1'b0;
    wait_stat(3);
    `CHK("reads", 16'h2, rk)
    `CHK("disc", 16'h1, dk)
    $display("read test done");
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("sync", 32'h1, rd)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("status", 32'h0, rd)
    $display("mid-run reset test done");
    finish_test();
  end
endmodule : dma_local_memory_channel_engine_tb_top
`default_nettype wire

// file: dmc_chan_model.sv
// behavioural channel adapter for one port: sends write parcels, acknowledges read parcels
`timescale 1ns/1ps
`default_nettype none
module dmc_chan_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sync_pulse,
  input wire logic tx_en,
  input wire logic ack_out,
  input wire logic rdy_out,
  output logic rdy_in,
  output logic ack_in,
  output logic [15:0] data_in
);
  logic [2:0] ph_ff;
  logic [2:0] cur;
  logic wait_ff;
  logic [15:0] k_ff;
  logic go;
  assign cur = sync_pulse ? 3'h0 : ph_ff;
  // a new parcel only after the last one was acknowledged
  assign go = tx_en && !wait_ff && (cur == 3'h2 || cur == 3'h5);
  always @(posedge ref_clk) begin
    ph_ff <= (cur == 3'h5) ? 3'h0 : cur + 3'h1;
    if (!reset_n) begin
      wait_ff <= 1'b0;
      k_ff <= 16'h0000;
      rdy_in <= 1'b0;
      ack_in <= 1'b0;
      data_in <= 16'hffff;
    end else begin
      rdy_in <= go;
      // data is only valid beside ready, so it toggles otherwise
      data_in <= go ? 16'ha000 + k_ff : ~data_in;
      k_ff <= go ? k_ff + 16'h0001 : k_ff;
      wait_ff <= go | (wait_ff & !ack_out);
      ack_in <= rdy_out;
    end
  end
endmodule : dmc_chan_model
`default_nettype wire

// file: dmc_engine.sv
// dma engine moving parcels between two channel ports and local memory
// Function
// RULE1: start code 1 sets busy, clears done and activates the channel.
// RULE2: write ready with data at phase 0 or 3 raises a write request.
// RULE3: a port reference request is raised only while the port is free.
// RULE4: check bits are generated for every parcel written to memory.
// RULE5: port request forwarded only when other port and workstation are quiet.
// RULE6: i/o grant only without processor request or after a processor grant; the two alternate priority.
// RULE7: on grant the port request clears and the port acknowledge goes out.
// RULE8: each grant drives the address, then increments it and decrements count.
// RULE9: address and count are parity checked on every read out.
// RULE10: on a write grant data, check bits and write enable go to memory.
// RULE11: write parcels are acknowledged to the channel at phase 1 or 4.
// RULE12: zero count with ready or disconnect ends a write; late parcel held.
// RULE13: next read request waits for the channel acknowledge of the last.
// RULE14: read parcels are checked and corrected before going to the channel.
// RULE15: read parcels go out with ready at phase 0 or 3.
// RULE16: channel acknowledge at phase 1 or 4 enables the next read parcel.
// RULE17: read ends at zero count or disconnect, disconnect sent at phase 2 or 5.
// RULE18: function code and channel are decoded and broadcast as go function.
// RULE19: codes 10,11,14,15 on channels 10-37 reach address and count instead.
// RULE20: function goes out as nibbles: modifier, command, then accumulator.
// RULE21: go function strobe reaches the selected channel only.
// RULE22: busy or done of the selected channel lands in the carry bit.
// RULE23: a free running six phase counter paces all channel controls.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
module dmc_engine (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_memory_or_fetch_request,
  output logic cpu_ack,
  input wire logic ws_req,
  input wire logic [1:0] ch_rdy_in,
  input wire logic [1:0] ch_ack_in,
  input wire logic [1:0] ch_disc_in,
  input wire logic [15:0] ch_data_in0,
  input wire logic [15:0] ch_data_in1,
  output logic [1:0] ch_rdy_out,
  output logic [1:0] ch_ack_out,
  output logic [1:0] ch_disc_out,
  output logic [15:0] ch_data_out0,
  output logic [15:0] ch_data_out1,
  output logic [15:0] mem_addr,
  output logic [21:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [21:0] mem_rdata,
  output logic go_fn,
  output logic [4:0] go_fn_chan,
  output logic [31:0] go_fn_strobe,
  output logic [3:0] fn_nibble,
  output logic fn_nibble_valid,
  output logic carry,
  output logic sync_pulse
);

  function automatic logic is_ph(input logic [2:0] ph, input logic [2:0] a);
    return (ph == a) || (ph == a + 3'h3);
  endfunction : is_ph

  function automatic logic [5:0] ecc_gen(input logic [15:0] d);
    logic [21:1] cw;
    logic [5:0] c;
    int k;
    cw = '0;
    c = '0;
    k = 0;
    for (int j = 1; j < 22; j++) begin
      if ((j & (j - 1)) != 0) begin
        cw[j] = d[k];
        k++;
      end
    end
    for (int j = 1; j < 22; j++) begin
      for (int i = 0; i < 5; i++) begin
        if (j[i]) c[i] = c[i] ^ cw[j];
      end
    end
    c[5] = ^{c[4:0], d};
    return c;
  endfunction : ecc_gen

  // returns {double error, corrected data}
  function automatic logic [16:0] ecc_fix(input logic [21:0] w);
    logic [15:0] d;
    logic [5:0] s;
    logic ov;
    int k;
    d = w[15:0];
    s = ecc_gen(d) ^ w[21:16];
    ov = ^w;
    k = 0;
    for (int j = 1; j < 22; j++) begin
      if ((j & (j - 1)) != 0) begin
        if (ov && (s[4:0] == j[4:0])) d[k] = ~d[k];
        k++;
      end
    end
    return {(!ov && (s[4:0] != 5'h00)), d};
  endfunction : ecc_fix

  // sync phase, plus the phase at which a synchronised pin value was driven
  logic [2:0] ph_ff, ph1_ff, ph2_ff;
  logic sync_pulse_ff;
  wire [2:0] ph_nx = (ph_ff == `DMC_SYNC_LAST) ? 3'h0 : ph_ff + 3'h1;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ph_ff <= 3'h0;
      ph1_ff <= 3'h0;
      ph2_ff <= 3'h0;
      sync_pulse_ff <= 1'b0;
    end else begin
      ph_ff <= ph_nx; // RULE23
      ph1_ff <= ph_ff;
      ph2_ff <= ph1_ff;
      sync_pulse_ff <= (ph_nx == 3'h0);
    end
  end
  assign sync_pulse = sync_pulse_ff;

  logic [1:0] rdy_s1_ff, rdy_s2_ff, ack_s1_ff, ack_s2_ff, disc_s1_ff, disc_s2_ff;
  logic [15:0] d0_s1_ff, d0_s2_ff, d1_s1_ff, d1_s2_ff;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdy_s1_ff <= 2'h0;
      rdy_s2_ff <= 2'h0;
      ack_s1_ff <= 2'h0;
      ack_s2_ff <= 2'h0;
      disc_s1_ff <= 2'h0;
      disc_s2_ff <= 2'h0;
      d0_s1_ff <= `DMC_RST_16;
      d0_s2_ff <= `DMC_RST_16;
      d1_s1_ff <= `DMC_RST_16;
      d1_s2_ff <= `DMC_RST_16;
    end else begin
      rdy_s1_ff <= ch_rdy_in;
      rdy_s2_ff <= rdy_s1_ff;
      ack_s1_ff <= ch_ack_in;
      ack_s2_ff <= ack_s1_ff;
      disc_s1_ff <= ch_disc_in;
      disc_s2_ff <= disc_s1_ff;
      d0_s1_ff <= ch_data_in0;
      d0_s2_ff <= d0_s1_ff;
      d1_s1_ff <= ch_data_in1;
      d1_s2_ff <= d1_s1_ff;
    end
  end
  wire [15:0] din [2];
  assign din[0] = d0_s2_ff;
  assign din[1] = d1_s2_ff;
  wire [1:0] rdy_ev = rdy_s2_ff & {2{is_ph(ph2_ff, 3'h0)}}; // RULE2
  wire [1:0] ack_ev = ack_s2_ff & {2{is_ph(ph2_ff, 3'h1)}}; // RULE16
  wire [1:0] disc_ev = disc_s2_ff & {2{is_ph(ph2_ff, 3'h2)}};

  // register bus and function decode
  logic [31:0] prdata_ff;
  logic [15:0] acc_ff;
  logic carry_ff, par_err_ff, ecc_err_ff;
  logic [2:0] nib_cnt_ff;
  wire acc_phase = psel && penable;
  wire a_func = (paddr == `DMC_OFS_FUNC);
  wire a_acc = (paddr == `DMC_OFS_ACC);
  wire a_stat = (paddr == `DMC_OFS_STAT);
  wire a_sync = (paddr == `DMC_OFS_SYNC);
  wire mapped = a_func || a_acc || a_stat || a_sync;
  // a new function stalls the bus while the last one is still fanning out
  assign pready = !(psel && pwrite && a_func && (nib_cnt_ff != 3'h0));
  assign pslverr = acc_phase && !mapped;
  wire fw = acc_phase && pwrite && a_func && pready;
  wire [3:0] fcode = pwdata[`DMC_FN_CODE_LSB+3:`DMC_FN_CODE_LSB]; // RULE18
  wire [3:0] fmod = pwdata[`DMC_FN_MOD_LSB+3:`DMC_FN_MOD_LSB];
  wire [4:0] fch = pwdata[4:0];
  wire fport = fch[0];
  wire in_rng = (fch >= `DMC_CH_LO);
  wire internal = in_rng && ((fcode == `DMC_FC_LD_LMA) || (fcode == `DMC_FC_LD_CNT) ||
                  (fcode == `DMC_FC_RD_LMA) || (fcode == `DMC_FC_RD_CNT)); // RULE19
  wire bcast = fw && !internal;

  // per-port state
  dmc_pkg::dmc_st_t st_ff [2];
  logic busy_ff [2], done_ff [2], rd_ff [2], held_ff [2];
  logic lma_par_ff [2], cnt_par_ff [2];
  logic rdy_o_ff [2], ack_o_ff [2], disc_o_ff [2];
  logic [15:0] lma_ff [2], cnt_ff [2], dat_ff [2];
  logic [4:0] chan_ff [2];

  // port and memory arbitration
  logic io_req_ff, io_sel_ff, rr_ff, last_io_ff;
  wire pend0 = (st_ff[0] == dmc_pkg::ST_REQ);
  wire pend1 = (st_ff[1] == dmc_pkg::ST_REQ);
  wire cpu_req = cpu_memory_or_fetch_request;
  wire io_ack = io_req_ff && !(cpu_req && last_io_ff); // RULE6
  assign cpu_ack = cpu_req && !io_ack;
  wire [1:0] port_ack = {io_ack && io_sel_ff, io_ack && !io_sel_ff}; // RULE7
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      io_req_ff <= 1'b0;
      io_sel_ff <= 1'b0;
      rr_ff <= 1'b0;
      last_io_ff <= 1'b0;
    end else begin
      if (io_ack) begin
        io_req_ff <= 1'b0; // RULE7
        rr_ff <= !io_sel_ff;
      end else if (!io_req_ff && !ws_req && (pend0 || pend1)) begin
        io_req_ff <= 1'b1; // RULE5
        io_sel_ff <= (pend0 && pend1) ? rr_ff : pend1;
      end
      if (io_ack) last_io_ff <= 1'b1;
      else if (cpu_ack) last_io_ff <= 1'b0;
    end
  end

  // address unit and memory side
  wire [15:0] g_lma = lma_ff[io_sel_ff];
  wire [15:0] g_cnt = cnt_ff[io_sel_ff];
  wire par_bad = (^{g_lma, lma_par_ff[io_sel_ff]}) || (^{g_cnt, cnt_par_ff[io_sel_ff]}); // RULE9
  wire fn_par_bad = (^{lma_ff[fport], lma_par_ff[fport]}) ||
                    (^{cnt_ff[fport], cnt_par_ff[fport]});
  logic [15:0] mem_addr_ff;
  logic [21:0] mem_wdata_ff;
  logic mem_we_ff, mem_re_ff, rd_wait_ff, rd_port_ff;
  wire [16:0] fixed = ecc_fix(mem_rdata); // RULE14
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mem_addr_ff <= `DMC_RST_16;
      mem_wdata_ff <= 22'h000000;
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      rd_port_ff <= 1'b0;
    end else begin
      mem_we_ff <= io_ack && !rd_ff[io_sel_ff] && !par_bad; // RULE10
      mem_re_ff <= io_ack && rd_ff[io_sel_ff] && !par_bad;
      if (io_ack) begin
        mem_addr_ff <= g_lma; // RULE8
        mem_wdata_ff <= {ecc_gen(dat_ff[io_sel_ff]), dat_ff[io_sel_ff]}; // RULE4
        rd_port_ff <= io_sel_ff;
      end
      rd_wait_ff <= mem_re_ff;
    end
  end
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_we = mem_we_ff;
  assign mem_re = mem_re_ff;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      wire sel = (fport == p);
      wire start = fw && (fcode == `DMC_FC_START) && in_rng && sel && !busy_ff[p];
      wire ldl = fw && internal && sel && (fcode == `DMC_FC_LD_LMA);
      wire ldc = fw && internal && sel && (fcode == `DMC_FC_LD_CNT);
      wire cnt0 = (cnt_ff[p] == `DMC_RST_16);
      wire cap = rd_wait_ff && (rd_port_ff == p);
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          st_ff[p] <= dmc_pkg::ST_IDLE;
          busy_ff[p] <= 1'b0;
          done_ff[p] <= 1'b0;
          rd_ff[p] <= 1'b0;
          held_ff[p] <= 1'b0;
          lma_ff[p] <= `DMC_RST_16;
          cnt_ff[p] <= `DMC_RST_16;
          dat_ff[p] <= `DMC_RST_16;
          lma_par_ff[p] <= 1'b0;
          cnt_par_ff[p] <= 1'b0;
          chan_ff[p] <= 5'h00;
          rdy_o_ff[p] <= 1'b0;
          ack_o_ff[p] <= 1'b0;
          disc_o_ff[p] <= 1'b0;
        end else begin
          rdy_o_ff[p] <= 1'b0;
          ack_o_ff[p] <= 1'b0;
          disc_o_ff[p] <= 1'b0;
          if (ldl) begin
            lma_ff[p] <= acc_ff; // RULE19
            lma_par_ff[p] <= ^acc_ff;
          end
          if (ldc) begin
            cnt_ff[p] <= acc_ff; // RULE19
            cnt_par_ff[p] <= ^acc_ff;
          end
          if (start) begin
            busy_ff[p] <= 1'b1; // RULE1
            done_ff[p] <= 1'b0;
            rd_ff[p] <= fmod[0];
            chan_ff[p] <= fch;
            st_ff[p] <= dmc_pkg::ST_ACTIVE;
          end else begin
            case (st_ff[p])
              dmc_pkg::ST_IDLE: begin
              end
              dmc_pkg::ST_ACTIVE: begin
                if (rd_ff[p]) begin
                  if (!cnt0) begin
                    st_ff[p] <= dmc_pkg::ST_REQ; // RULE3
                  end else if (is_ph(ph_nx, 3'h2)) begin
                    disc_o_ff[p] <= 1'b1; // RULE17
                    busy_ff[p] <= 1'b0;
                    done_ff[p] <= 1'b1;
                    st_ff[p] <= dmc_pkg::ST_IDLE;
                  end
                end else if (held_ff[p]) begin
                  // a parcel parked at the end of the last transfer goes first
                  if (!cnt0) begin
                    held_ff[p] <= 1'b0;
                    st_ff[p] <= dmc_pkg::ST_REQ;
                  end else if (disc_ev[p]) begin
                    busy_ff[p] <= 1'b0;
                    done_ff[p] <= 1'b1;
                    st_ff[p] <= dmc_pkg::ST_IDLE;
                  end
                end else if (rdy_ev[p]) begin
                  dat_ff[p] <= din[p]; // RULE2
                  if (cnt0) begin
                    held_ff[p] <= 1'b1; // RULE12
                    busy_ff[p] <= 1'b0;
                    done_ff[p] <= 1'b1;
                    st_ff[p] <= dmc_pkg::ST_IDLE;
                  end else begin
                    st_ff[p] <= dmc_pkg::ST_REQ; // RULE3
                  end
                end else if (disc_ev[p] && cnt0) begin
                  busy_ff[p] <= 1'b0; // RULE12
                  done_ff[p] <= 1'b1;
                  st_ff[p] <= dmc_pkg::ST_IDLE;
                end
              end
              dmc_pkg::ST_REQ: begin
                if (port_ack[p]) begin
                  lma_ff[p] <= lma_ff[p] + 16'h0001; // RULE8
                  cnt_ff[p] <= cnt_ff[p] - 16'h0001;
                  lma_par_ff[p] <= ^(lma_ff[p] + 16'h0001);
                  cnt_par_ff[p] <= ^(cnt_ff[p] - 16'h0001);
                  if (par_bad) begin
                    busy_ff[p] <= 1'b0; // RULE9
                    done_ff[p] <= 1'b1;
                    st_ff[p] <= dmc_pkg::ST_IDLE;
                  end else begin
                    st_ff[p] <= rd_ff[p] ? dmc_pkg::ST_MEMRD : dmc_pkg::ST_ACKW;
                  end
                end
              end
              dmc_pkg::ST_MEMRD: begin
                if (cap) begin
                  dat_ff[p] <= fixed[15:0]; // RULE14
                  st_ff[p] <= dmc_pkg::ST_SEND;
                end
              end
              dmc_pkg::ST_SEND: begin
                if (is_ph(ph_nx, 3'h0)) begin
                  rdy_o_ff[p] <= 1'b1; // RULE15
                  st_ff[p] <= dmc_pkg::ST_WAITACK;
                end
              end
              dmc_pkg::ST_WAITACK: begin
                if (ack_ev[p]) st_ff[p] <= dmc_pkg::ST_ACTIVE; // RULE13
              end
              dmc_pkg::ST_ACKW: begin
                if (is_ph(ph_nx, 3'h1)) begin
                  ack_o_ff[p] <= 1'b1; // RULE11
                  st_ff[p] <= dmc_pkg::ST_ACTIVE;
                end
              end
              default: st_ff[p] <= dmc_pkg::ST_IDLE;
            endcase
            if (rd_ff[p] && busy_ff[p] && disc_ev[p]) begin
              busy_ff[p] <= 1'b0; // RULE17
              done_ff[p] <= 1'b1;
              st_ff[p] <= dmc_pkg::ST_IDLE;
            end
          end
        end
      end
    end
  endgenerate
  assign ch_rdy_out = {rdy_o_ff[1], rdy_o_ff[0]};
  assign ch_ack_out = {ack_o_ff[1], ack_o_ff[0]};
  assign ch_disc_out = {disc_o_ff[1], disc_o_ff[0]};
  assign ch_data_out0 = dat_ff[0];
  assign ch_data_out1 = dat_ff[1];

  // function fanout, accumulator, carry, error flags
  logic go_fn_ff, nib_v_ff;
  logic [4:0] go_ch_ff;
  logic [31:0] strobe_ff;
  logic [23:0] nib_sh_ff;
  logic [3:0] nib_ff;
  logic [31:0] func_ff;
  wire hit = busy_ff[fport] ? (chan_ff[fport] == fch) : (chan_ff[fport] == fch);
  wire st_wr = acc_phase && pwrite && a_stat;
  wire perr_set = (io_ack && par_bad) ||
                  (fw && internal && ((fcode == `DMC_FC_RD_LMA) || (fcode == `DMC_FC_RD_CNT)) &&
                   fn_par_bad);
  wire eerr_set = rd_wait_ff && fixed[16];
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      go_fn_ff <= 1'b0;
      go_ch_ff <= 5'h00;
      strobe_ff <= 32'h00000000;
      nib_cnt_ff <= 3'h0;
      nib_sh_ff <= 24'h000000;
      nib_ff <= 4'h0;
      nib_v_ff <= 1'b0;
      acc_ff <= `DMC_RST_16;
      carry_ff <= 1'b0;
      func_ff <= 32'h00000000;
      par_err_ff <= 1'b0;
      ecc_err_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      go_fn_ff <= bcast; // RULE18
      strobe_ff <= bcast ? (32'h00000001 << fch) : 32'h00000000; // RULE21
      if (bcast) go_ch_ff <= fch;
      if (bcast) begin
        nib_sh_ff <= {acc_ff, fcode, fmod}; // RULE20
        nib_cnt_ff <= `DMC_NIBBLES;
      end else if (nib_cnt_ff != 3'h0) begin
        nib_sh_ff <= {4'h0, nib_sh_ff[23:4]};
        nib_cnt_ff <= nib_cnt_ff - 3'h1;
      end
      nib_v_ff <= (nib_cnt_ff != 3'h0) && !bcast;
      if ((nib_cnt_ff != 3'h0) && !bcast) nib_ff <= nib_sh_ff[3:0];
      if (fw) func_ff <= pwdata;
      if (acc_phase && pwrite && a_acc) acc_ff <= pwdata[15:0];
      else if (fw && internal && (fcode == `DMC_FC_RD_LMA)) acc_ff <= lma_ff[fport];
      else if (fw && internal && (fcode == `DMC_FC_RD_CNT)) acc_ff <= cnt_ff[fport];
      if (fw && (fcode == `DMC_FC_TBUSY)) carry_ff <= in_rng && hit && busy_ff[fport]; // RULE22
      if (fw && (fcode == `DMC_FC_TDONE)) carry_ff <= in_rng && hit && done_ff[fport]; // RULE22
      // a fresh error outweighs a clear in the same cycle
      par_err_ff <= perr_set || (par_err_ff && !(st_wr && pwdata[`DMC_STAT_PERR]));
      ecc_err_ff <= eerr_set || (ecc_err_ff && !(st_wr && pwdata[`DMC_STAT_EERR]));
      if (psel && !penable) begin
        prdata_ff <= a_func ? func_ff :
                     a_acc ? {16'h0000, acc_ff} :
                     a_stat ? {23'h000000, held_ff[1], held_ff[0], ecc_err_ff, par_err_ff,
                               carry_ff, done_ff[1], done_ff[0], busy_ff[1], busy_ff[0]} :
                     a_sync ? {29'h00000000, ph_ff} : 32'h00000000;
      end
    end
  end
  assign prdata = prdata_ff;
  assign go_fn = go_fn_ff;
  assign go_fn_chan = go_ch_ff;
  assign go_fn_strobe = strobe_ff;
  assign fn_nibble = nib_ff;
  assign fn_nibble_valid = nib_v_ff;
  assign carry = carry_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_go;
    go_fn_ff;
  endsequence
  sequence s_burst;
    nib_v_ff [*6] ##1 !nib_v_ff;
  endsequence
  a_start_flags: assert property (g_port[0].start |=> busy_ff[0] && !done_ff[0]) // RULE1
    else $error("start did not set busy and clear done");
  a_fwd_quiet: assert property ($rose(io_req_ff) |-> !$past(ws_req)) // RULE5
    else $error("i/o request forwarded during workstation request");
  a_io_alternate: assert property ((io_ack && cpu_req) ##1 cpu_req |-> cpu_ack) // RULE6
    else $error("processor not served after an i/o grant");
  a_port_clear: assert property (io_ack |=> !io_req_ff) // RULE7
    else $error("port request not cleared after grant");
  a_addr_step: assert property (port_ack[0] |=> (lma_ff[0] == $past(lma_ff[0]) + 16'h0001)
    && (cnt_ff[0] == $past(cnt_ff[0]) - 16'h0001) && (mem_addr == $past(lma_ff[0]))) // RULE8
    else $error("address or count step wrong");
  a_we_data: assert property (port_ack[0] && !rd_ff[0] && !par_bad |=> mem_we &&
    (mem_wdata == {ecc_gen($past(dat_ff[0])), $past(dat_ff[0])})) // RULE10
    else $error("write parcel not sent with check bits");
  a_ack_phase: assert property ((ch_ack_out != 2'h0) |-> is_ph(ph_ff, 3'h1)) // RULE11
    else $error("acknowledge outside phase 1 or 4");
  a_rdy_phase: assert property ((ch_rdy_out != 2'h0) |-> is_ph(ph_ff, 3'h0)) // RULE15
    else $error("ready outside phase 0 or 3");
  a_disc_phase: assert property (ch_disc_out[0] |-> is_ph(ph_ff, 3'h2) && done_ff[0]) // RULE17
    else $error("disconnect misplaced");
  a_read_wait: assert property ((st_ff[0] == dmc_pkg::ST_WAITACK) && !ack_ev[0] &&
    !disc_ev[0] |=> st_ff[0] == dmc_pkg::ST_WAITACK) // RULE13
    else $error("read moved on before acknowledge");
  a_nib_burst: assert property (s_go |=> s_burst) // RULE20
    else $error("function nibble burst length wrong");
  a_one_strobe: assert property ((go_fn_strobe != 32'h0) |-> $onehot(go_fn_strobe) &&
    (go_fn_strobe == (32'h00000001 << go_fn_chan))) // RULE21
    else $error("strobe not to the selected channel alone");
endmodule : dmc_engine
`default_nettype wire

// file: dmc_params.svh
// offsets, field positions, reset values and counts of the dma channel engine
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH
`define DMC_OFS_FUNC 8'h00
`define DMC_OFS_ACC 8'h04
`define DMC_OFS_STAT 8'h08
`define DMC_OFS_SYNC 8'h0c
`define DMC_FN_CODE_LSB 9
`define DMC_FN_MOD_LSB 5
`define DMC_STAT_PERR 5
`define DMC_STAT_EERR 6
`define DMC_FC_START 4'h1
`define DMC_FC_TBUSY 4'h2
`define DMC_FC_TDONE 4'h3
`define DMC_FC_LD_LMA 4'h8
`define DMC_FC_LD_CNT 4'h9
`define DMC_FC_RD_LMA 4'hc
`define DMC_FC_RD_CNT 4'hd
`define DMC_CH_LO 5'h08
`define DMC_SYNC_LAST 3'h5
`define DMC_NIBBLES 3'h6
`define DMC_RST_16 16'h0000
`endif

// file: dmc_pkg.sv
// types of the dma channel engine
package dmc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACTIVE, ST_REQ, ST_MEMRD, ST_SEND, ST_WAITACK, ST_ACKW
  } dmc_st_t;
endpackage : dmc_pkg
